// *** dv/txcb_bank_monitor.sv ***
// Checker for the control and status bank, bound to txcb_bank.
// Assumes one clock, mclk, and asynchronous rst.
`timescale 1ns/1ps
`default_nettype none
module txcb_bank_monitor (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_rvalid,
    input wire logic       buf_enable,
    input wire logic       pll_enable,
    input wire logic       bcast_mode,
    input wire logic [2:0] clk_mult_eff,
    input wire logic       cw_ron_sel,
    input wire logic [1:0] bmode_current_sel,
    input wire logic [4:0] tr_switch_delay_sel,
    input wire logic       tx_hiz,
    input wire logic       return_zero_start,
    input wire logic       soft_reset_pulse
);
    // Writes beside a soft reset may be wiped, so left out
    wire ok    = reg_wr && !soft_reset_pulse;
    wire w_ctl = ok && reg_addr == 8'h00 && !reg_wdata[6];
    wire w_cfg = ok && reg_addr == 8'h02;
    wire w_div = ok && reg_addr == 8'h03;
    wire w_tr  = ok && reg_addr == 8'h04;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    a_buf_from_bit: assert property (
        w_ctl && reg_wdata[0] |=> buf_enable == $past(reg_wdata[1]))
        else $error("buffer enable not from its bit");
    a_pll_from_bit: assert property (
        w_ctl && reg_wdata[2] |=> pll_enable == $past(reg_wdata[3]))
        else $error("pll enable not from its bit");
    a_bcast_from_bit: assert property (
        w_ctl && reg_wdata[4] |=> bcast_mode == $past(reg_wdata[5]))
        else $error("broadcast not from its bit");
    a_mult_bypass: assert property (
        !pll_enable |=> clk_mult_eff == 3'h1)
        else $error("multiplier applied while pll off");
    a_hiz_zero_div: assert property (
        w_div ##1 !reg_wr |-> ##1 tx_hiz == ($past(reg_wdata, 2) == 8'h00))
        else $error("hiz does not match divisor");
    a_cfg_fields: assert property (
        w_cfg |=> {bmode_current_sel, cw_ron_sel} == $past(reg_wdata[5:3]))
        else $error("cfg fields wrong");
    a_tr_switch_field: assert property (
        w_tr |=> tr_switch_delay_sel == $past(reg_wdata[4:0]))
        else $error("tr_switch field wrong");
    a_rvalid_pulse: assert property (
        reg_rvalid == $past(reg_rd))
        else $error("read answer not one cycle after strobe");
    a_unmapped_zero: assert property (
        reg_rd && reg_addr > 8'h04 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_srst_clears: assert property (
        ok && reg_addr == 8'h00 && reg_wdata[6] |=> soft_reset_pulse
        ##1 (!soft_reset_pulse && tr_switch_delay_sel == 5'h00 && !cw_ron_sel))
        else $error("soft reset did not clear");
    a_rz_single: assert property (
        return_zero_start |=> !return_zero_start)
        else $error("return to zero pulse too long");
    c_bit_mode: cover property (w_ctl && reg_wdata[0]);
    c_rz: cover property (return_zero_start);
    c_srst: cover property (soft_reset_pulse);
endmodule // txcb_bank_monitor
bind txcb_bank txcb_bank_monitor txcb_bank_monitor_i (
    .mclk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_rvalid, .buf_enable, .pll_enable, .bcast_mode, .clk_mult_eff,
    .cw_ron_sel, .bmode_current_sel, .tr_switch_delay_sel, .tx_hiz,
    .return_zero_start, .soft_reset_pulse);
`default_nettype wire

// *** dv/txcb_bank_tb.sv ***
// Self-checking bench for the control and status bank.
// Assumes the master model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module txcb_bank_tb;
    logic        mclk = 1'h0, rst = 1'h1;
    logic        reg_wr, reg_rd, reg_rvalid, buf_enable, pll_enable;
    logic        bcast_mode, cw_ron_sel, tx_hiz, fault_out_n;
    logic        return_zero_start, soft_reset_pulse;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic [2:0]  clk_mult_eff;
    logic [1:0]  bmode_current_sel;
    logic [4:0]  tr_switch_delay_sel;
    logic [15:0] cw_wave;
    logic        buf_enable_pin = 1'h0, pll_enable_pin = 1'h0;
    logic        bcast_pin = 1'h0, pll_locked = 1'h0, overtemp_in = 1'h0;
    logic        enable_in = 1'h0, cw_pin = 1'h0, tx_trigger = 1'h0;
    logic        end_tx_input = 1'h0;
    logic [2:0]  undervolt_in = 3'h0;
    logic [15:0] ch_done = 16'h0, delay_done = 16'h0;
    int          miscompares = 0, n_compared = 0, n;
    txcb_bank txcb_bank_i (.mclk, .rst, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata, .reg_rvalid, .buf_enable_pin,
        .pll_enable_pin, .bcast_pin, .pll_locked, .overtemp_in,
        .undervolt_in, .enable_in, .cw_pin, .tx_trigger, .end_tx_input,
        .ch_done, .delay_done, .buf_enable, .pll_enable, .bcast_mode,
        .clk_mult_eff, .cw_ron_sel, .bmode_current_sel, .tr_switch_delay_sel,
        .tx_hiz, .cw_wave, .fault_out_n, .return_zero_start,
        .soft_reset_pulse);
    txcb_master_model m (.mclk, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata);
    always #25 mclk = ~mclk;
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e,
                      input string nm);
        logic [7:0] d;
        m.rd(a, d);
        chk(nm, d, e);
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
        #2;
    endtask
    task automatic span(input logic v, output int c);
        c = 0;
        while (cw_wave[0] === v && c < 20) begin
            cyc(1);
            c++;
        end
    endtask
    task automatic wait_rz(output int c);
        c = 0;
        while (return_zero_start !== 1'h1 && c < 10) begin
            cyc(1);
            c++;
        end
    endtask
    task automatic end_of_test;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Whole run is well under 1000 cycles
    initial begin
        #200000;
        miscompares++;
        end_of_test();
    end
    initial begin
        cyc(5);
        rst = 1'h0;
        // First status read clears stale flags
        for (n = 0; n < 8; n++)
            rc(n[7:0], 8'h00, "reset");
        chk("hiz", tx_hiz, 1'h1);
        {buf_enable_pin, pll_enable_pin, bcast_pin} = 3'h7;
        cyc(3);
        chk("pin", {buf_enable, pll_enable, bcast_mode}, 3'h7);
        m.wr(8'h00, 8'h15);
        chk("bit0", {buf_enable, pll_enable, bcast_mode}, 3'h0);
        {buf_enable_pin, pll_enable_pin, bcast_pin} = 3'h0;
        m.wr(8'h00, 8'h3f);
        cyc(3);
        chk("bit1", {buf_enable, pll_enable, bcast_mode}, 3'h7);
        rc(8'h00, 8'h3f, "ctrl");
        m.wr(8'h00, 8'h2a);
        chk("pinsel", {buf_enable, pll_enable, bcast_mode}, 3'h0);
        for (n = 1; n < 8; n++) begin
            m.wr(8'h02, {2'h3, n[1:0], n[2], 3'h5});
            rc(8'h02, {2'h0, n[1:0], n[2], 3'h5}, "cfg");
            chk("drive", {cw_ron_sel, bmode_current_sel}, n[2:0]);
        end
        m.wr(8'h00, 8'h0c);
        pll_locked = 1'h1;
        cyc(4);
        chk("mult", clk_mult_eff, 3'h5);
        pll_locked = 1'h0;
        cyc(4);
        chk("bypass", clk_mult_eff, 3'h1);
        m.wr(8'h04, 8'hff);
        rc(8'h04, 8'h1f, "tr_switch_delay_sel");
        m.wr(8'h03, 8'h03);
        cw_pin = 1'h1;
        cyc(4);
        chk("hiz0", tx_hiz, 1'h0);
        {tx_trigger, delay_done} = 17'h10001;
        span(1'h0, n);
        // Two synchroniser edges, then one full divisor count
        chk("cw_lead", n, 5);
        chk("cw_dly", cw_wave[1], 1'h0);
        span(1'h1, n);
        chk("cw_half", n, 3);
        {cw_pin, tx_trigger, delay_done} = 18'h0;
        overtemp_in = 1'h1;
        cyc(4);
        chk("fault", fault_out_n, 1'h0);
        rc(8'h01, 8'h01, "ot");
        rc(8'h01, 8'h00, "ot_clr");
        chk("fault_hi", fault_out_n, 1'h1);
        enable_in = 1'h1;
        cyc(4);
        chk("refault", fault_out_n, 1'h0);
        overtemp_in = 1'h0;
        rc(8'h01, 8'h01, "ot2");
        undervolt_in = 3'h5;
        cyc(4);
        rc(8'h01, 8'h0a, "uv");
        rc(8'h01, 8'h00, "uv_clr");
        enable_in = 1'h0;
        cyc(3);
        enable_in = 1'h1;
        cyc(4);
        rc(8'h01, 8'h0a, "uv_again");
        {undervolt_in, pll_locked, ch_done} = 20'h17fff;
        cyc(4);
        rc(8'h01, 8'h20, "lock");
        ch_done = 16'hffff;
        wait_rz(n);
        chk("rz0", n < 10, 1'h1);
        rc(8'h01, 8'h30, "done");
        ch_done = 16'h0;
        m.wr(8'h00, 8'h80);
        ch_done = 16'hffff;
        wait_rz(n);
        chk("rz_hold", n, 10);
        end_tx_input = 1'h1;
        wait_rz(n);
        chk("rz1", n < 10, 1'h1);
        m.wr(8'h00, 8'h40);
        chk("srst", soft_reset_pulse, 1'h1);
        rc(8'h04, 8'h00, "srst_tr");
        rc(8'h00, 8'h00, "srst_ctl");
        chk("srst_hiz", tx_hiz, 1'h1);
        end_of_test();
    end
endmodule // txcb_bank_tb
`default_nettype wire

// *** dv/txcb_master_model.sv ***
// Master model standing in for the I2C master on the byte port.
// Assumes mclk from the bench; drives 2 ns after rising edges.
`timescale 1ns/1ps
`default_nettype none
module txcb_master_model (
    input  wire logic       mclk,
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
    end
    // ------------------------------------------------------------
    // Byte access
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk) #2;
        reg_wr = 1'h1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge mclk) #2;
        reg_wr = 1'h0;
        // Idle bus never shows the last value
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    // Pointer byte, then one byte back
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk) #2;
        reg_rd = 1'h1;
        reg_addr = a;
        @(posedge mclk) #2;
        reg_rd = 1'h0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask
endmodule // txcb_master_model
`default_nettype wire

// *** hw/txcb_bank.v ***
// Control and status bit bank of a 16-channel transmitter, with the
// pin/register source selection, CW divider and fault flag logic.
// Assumes an I2C slave engine on mclk drives the byte access port
// and that analog/pin inputs are asynchronous to mclk.
//
// What this block does
// RULE1: Buffer enable comes from pin when select is 0, register bit when 1.
// RULE2: The unselected buffer-enable source has no effect at all.
// RULE3: PLL enable comes from pin at select 0, register bit at 1.
// RULE4: Broadcast mode comes from pin at select 0, register bit at 1.
// RULE5: Clock multiplier applies only when PLL enabled and locked, else x1.
// RULE6: CW output frequency is internal clock over two times divisor.
// RULE7: CW divisor resets to zero; zero holds transmit outputs high impedance.
// RULE8: With CW pin high, divisor loads into channel counters before trigger rise.
// RULE9: A channel CW counter decrements only after its beamform delay elapsed.
// RULE10: One on-resistance bit for all channels: 0 is 30 ohm, 1 is 45.
// RULE11: Two-bit B-mode current select shared by all channels.
// RULE12: Overtemperature flag sets on overtemperature, clears on status read.
// RULE13: Persisting overtemperature drives fault low again at next enable rise.
// RULE14: Per-rail undervoltage flags behave like the overtemperature flag.
// RULE15: Master reads status after power-on to clear stale flags.
// RULE16: Five-bit T/R switch delay select picks 8 to 288 clock periods.
// RULE17: Soft-reset bit resets the control, config, divisor and T/R registers like hardware reset, keeps status flags, self-clears.
// RULE18: End-of-transmit mode 0 starts return-to-zero period when channels finish.
// RULE19: Mode 1 starts it when end-transmit input high and channels finished.
// RULE20: Read-only done status is 1 only when all 16 channels finished.
// RULE21: Read-only lock status mirrors PLL lock.
// RULE22: Every control and status bit resets to zero.
// RULE23: Master reads via pointer write, repeated start, one-byte read.
// RULE24: Writes update only named control bits; status bits ignore writes.
`timescale 1ns/1ps
`include "txcb_defines.vh"
`default_nettype none

module txcb_bank (
    input  wire        mclk,
    input  wire        rst,
    // Byte access port from the I2C slave engine
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    output reg         reg_rvalid,
    // Asynchronous pins and analog status
    input  wire        buf_enable_pin,
    input  wire        pll_enable_pin,
    input  wire        bcast_pin,
    input  wire        pll_locked,
    input  wire        overtemp_in,
    input  wire [2:0]  undervolt_in,
    input  wire        enable_in,
    input  wire        cw_pin,
    input  wire        tx_trigger,
    input  wire        end_tx_input,
    input  wire [15:0] ch_done,
    input  wire [15:0] delay_done,
    // Resolved controls
    output wire        buf_enable,
    output wire        pll_enable,
    output wire        bcast_mode,
    output reg  [2:0]  clk_mult_eff,
    output wire        cw_ron_sel,
    output wire [1:0]  bmode_current_sel,
    output wire [4:0]  tr_switch_delay_sel,
    output reg         tx_hiz,
    output reg  [15:0] cw_wave,
    output reg         fault_out_n,
    output reg         return_zero_start,
    output reg         soft_reset_pulse
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam SW = 44;
    wire [SW-1:0] async_in = {buf_enable_pin, pll_enable_pin, bcast_pin,
                              pll_locked, overtemp_in, undervolt_in,
                              enable_in, cw_pin, tx_trigger, end_tx_input,
                              ch_done, delay_done};
    reg  [SW-1:0] sync1_q;
    reg  [SW-1:0] sync2_q;

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync1_q <= {SW{1'b0}};
            sync2_q <= {SW{1'b0}};
        end else begin
            sync1_q <= async_in;
            sync2_q <= sync1_q;
        end
    end

    wire        s_buf_pin  = sync2_q[43];
    wire        s_pll_pin  = sync2_q[42];
    wire        s_bc_pin   = sync2_q[41];
    wire        s_locked   = sync2_q[40];
    wire        s_ot       = sync2_q[39];
    wire [2:0]  s_uv       = sync2_q[38:36];
    wire        s_en       = sync2_q[35];
    wire        s_cw       = sync2_q[34];
    wire        s_trig     = sync2_q[33];
    wire        s_eti      = sync2_q[32];
    wire [15:0] s_done     = sync2_q[31:16];
    wire [15:0] s_dly      = sync2_q[15:0];

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Register bit when the source select is set, else the pin
    function txcb_pick;
        input sel;
        input reg_bit;
        input pin_val;
        begin
            txcb_pick = sel ? reg_bit : pin_val;
        end
    endfunction

    // A zero divisor parks the transmit outputs
    function txcb_is_zero;
        input [7:0] value;
        begin
            txcb_is_zero = (value == 8'h00);
        end
    endfunction

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    reg [7:0] ctrl_q;
    reg [7:0] cfg_q;
    reg [7:0] cw_divisor_q;
    reg [4:0] tr_switch_delay_sel_q;
    reg       ot_flag_q;
    reg [2:0] uv_flag_q;
    reg       en_q;
    reg       ot_q;
    reg [2:0] uv_q;
    reg       eot_arm_q;

    // Soft reset is applied one cycle after the write as a sync clear
    wire srst = soft_reset_pulse;
    wire wr_ctrl   = reg_wr && (reg_addr == `TXCB_ADDR_CTRL);
    wire rd_status = reg_rd && (reg_addr == `TXCB_ADDR_STATUS);
    wire en_rise   = s_en && !en_q;
    wire all_done  = &s_done;

    wire [7:0] status_byte;
    assign status_byte = {2'b00, s_locked, all_done,                 // [RULE20] [RULE21]
                          uv_flag_q, ot_flag_q};

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_q           <= `TXCB_RST_BYTE;                       // [RULE22]
            cfg_q            <= `TXCB_RST_BYTE;
            cw_divisor_q     <= `TXCB_RST_BYTE;                       // [RULE7]
            tr_switch_delay_sel_q          <= 5'h00;
            soft_reset_pulse <= 1'b0;
        end else if (srst) begin
            ctrl_q           <= `TXCB_RST_BYTE;                       // [RULE17]
            cfg_q            <= `TXCB_RST_BYTE;
            cw_divisor_q     <= `TXCB_RST_BYTE;
            tr_switch_delay_sel_q          <= 5'h00;
            soft_reset_pulse <= 1'b0;
        end else begin
            soft_reset_pulse <= wr_ctrl && reg_wdata[`TXCB_CTL_SRST]; // [RULE17]
            if (reg_wr) begin
                case (reg_addr)                                       // [RULE24]
                    `TXCB_ADDR_CTRL:
                        ctrl_q <= reg_wdata & 8'hbf;  // Reset bit never stored
                    `TXCB_ADDR_CFG:
                        cfg_q <= reg_wdata & 8'h3f;
                    `TXCB_ADDR_CWDIV:
                        cw_divisor_q <= reg_wdata;
                    `TXCB_ADDR_TR_SWITCH_DELAY_SEL:
                        tr_switch_delay_sel_q <= reg_wdata[4:0];
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    `TXCB_ADDR_CTRL:   reg_rdata <= ctrl_q;
                    `TXCB_ADDR_STATUS: reg_rdata <= status_byte;
                    `TXCB_ADDR_CFG:    reg_rdata <= cfg_q;
                    `TXCB_ADDR_CWDIV:  reg_rdata <= cw_divisor_q;
                    `TXCB_ADDR_TR_SWITCH_DELAY_SEL:  reg_rdata <= {3'b000, tr_switch_delay_sel_q};
                    default:           reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Source selection and shared settings
    // ------------------------------------------------------------
    assign buf_enable = txcb_pick(ctrl_q[`TXCB_CTL_BUF_SRC],  // [RULE1]
        ctrl_q[`TXCB_CTL_BUF_EN], s_buf_pin);                 // [RULE2]
    assign pll_enable = txcb_pick(ctrl_q[`TXCB_CTL_PLL_SRC],  // [RULE3]
        ctrl_q[`TXCB_CTL_PLL_EN], s_pll_pin);
    assign bcast_mode = txcb_pick(ctrl_q[`TXCB_CTL_BC_SRC],   // [RULE4]
        ctrl_q[`TXCB_CTL_BC_EN], s_bc_pin);
    assign cw_ron_sel = cfg_q[`TXCB_CFG_RON];                         // [RULE10]
    assign bmode_current_sel =
        cfg_q[`TXCB_CFG_BOC_HI:`TXCB_CFG_BOC_LO];                     // [RULE11]
    assign tr_switch_delay_sel = tr_switch_delay_sel_q;                                  // [RULE16]

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            clk_mult_eff <= `TXCB_MUL_BYPASS;
            tx_hiz       <= 1'b1;
        end else begin
            // Unlocked PLL falls back to the reference clock
            clk_mult_eff <= (pll_enable && s_locked) ?                // [RULE5]
                            cfg_q[`TXCB_CFG_MUL_HI:`TXCB_CFG_MUL_LO] :
                            `TXCB_MUL_BYPASS;
            tx_hiz       <= txcb_is_zero(cw_divisor_q);               // [RULE7]
        end
    end

    // ------------------------------------------------------------
    // Fault flags
    // ------------------------------------------------------------
    // Set on a new condition, or on enable rise while it persists.
    // A set in the clearing cycle wins over the read.
    wire       ot_set = s_ot && (!ot_q || en_rise);                   // [RULE13]
    wire [2:0] uv_set = s_uv & (~uv_q | {3{en_rise}});                // [RULE14]

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            ot_flag_q   <= 1'b0;
            uv_flag_q   <= 3'b000;
            en_q        <= 1'b0;
            ot_q        <= 1'b0;
            uv_q        <= 3'b000;
            fault_out_n <= 1'b1;
        end else begin
            en_q <= s_en;
            ot_q <= s_ot;
            uv_q <= s_uv;
            ot_flag_q <= ot_set | (ot_flag_q & ~rd_status);           // [RULE12]
            uv_flag_q <= uv_set | (uv_flag_q & {3{~rd_status}});      // [RULE14]
            fault_out_n <= ~(ot_set | (|uv_set) |
                             ((ot_flag_q | (|uv_flag_q)) & ~rd_status));
        end
    end

    // ------------------------------------------------------------
    // End of transmit
    // ------------------------------------------------------------
    wire eot_cond = ctrl_q[`TXCB_CTL_EOT_TIMING_SEL] ? (all_done && s_eti)      // [RULE19]
                                           : all_done;                // [RULE18]

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            eot_arm_q         <= 1'b0;
            return_zero_start <= 1'b0;
        end else begin
            eot_arm_q         <= eot_cond;
            return_zero_start <= eot_cond && !eot_arm_q;
        end
    end

    // ------------------------------------------------------------
    // Per-channel CW dividers
    // ------------------------------------------------------------
    // Half period is the divisor, so a full period is twice it.
    reg [7:0] cw_cnt_q [0:15];
    integer   ch;

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            cw_wave <= 16'h0000;
            for (ch = 0; ch < `TXCB_NCH; ch = ch + 1)
                cw_cnt_q[ch] <= 8'h00;
        end else begin
            for (ch = 0; ch < `TXCB_NCH; ch = ch + 1) begin
                if (s_cw && !s_trig) begin
                    cw_cnt_q[ch] <= cw_divisor_q;                     // [RULE8]
                    cw_wave[ch]  <= 1'b0;
                end else if (s_cw && s_dly[ch] &&                     // [RULE9]
                             !txcb_is_zero(cw_divisor_q)) begin
                    if (cw_cnt_q[ch] <= 8'h01) begin
                        cw_cnt_q[ch] <= cw_divisor_q;                 // [RULE6]
                        cw_wave[ch]  <= ~cw_wave[ch];
                    end else begin
                        cw_cnt_q[ch] <= cw_cnt_q[ch] - 8'h01;
                    end
                end
            end
        end
    end

endmodule // txcb_bank

`default_nettype wire

// *** hw/txcb_defines.vh ***
// Constants of the transmitter control and status bank.
// Assumes inclusion by its bare name from the design file only.
`ifndef TXCB_DEFINES_VH
`define TXCB_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TXCB_ADDR_CTRL      8'h00
`define TXCB_ADDR_STATUS    8'h01
`define TXCB_ADDR_CFG       8'h02
`define TXCB_ADDR_CWDIV     8'h03
`define TXCB_ADDR_TR_SWITCH_DELAY_SEL     8'h04

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define TXCB_CTL_BUF_SRC    0
`define TXCB_CTL_BUF_EN     1
`define TXCB_CTL_PLL_SRC    2
`define TXCB_CTL_PLL_EN     3
`define TXCB_CTL_BC_SRC     4
`define TXCB_CTL_BC_EN      5
`define TXCB_CTL_SRST       6
`define TXCB_CTL_EOT_TIMING_SEL       7

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define TXCB_ST_OT          0
`define TXCB_ST_UV_LO       1
`define TXCB_ST_UV_HI       3
`define TXCB_ST_EOT         4
`define TXCB_ST_LOCK        5

// ----------------------------------------------------------------
// Configuration register fields
// ----------------------------------------------------------------
`define TXCB_CFG_MUL_LO     0
`define TXCB_CFG_MUL_HI     2
`define TXCB_CFG_RON        3
`define TXCB_CFG_BOC_LO     4
`define TXCB_CFG_BOC_HI     5

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define TXCB_NCH            16
`define TXCB_NRAIL          3
`define TXCB_TR_SWITCH_DELAY_SEL_W        5
`define TXCB_RST_BYTE       8'h00
`define TXCB_MUL_BYPASS     3'h1

`endif
